// >>> common/xfer_svc_pkg.sv
package xfer_svc_pkg;
  // Register byte offsets on the APB slave
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_COUNT    = 8'h04;
  localparam logic [7:0] OFS_IOPTR    = 8'h08;
  localparam logic [7:0] OFS_BUFPTR   = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_TRIG     = 8'h1C;
  // Fields of channel_status_ctrl
  localparam int BIT_STOP_EN  = 0;
  localparam int BIT_DIR      = 1;
  localparam int BIT_BUF_HOLD = 2;
  localparam int BIT_WIDTH    = 3;
  localparam int BIT_IO_HOLD  = 4;
  // Fields of the status register
  localparam int BIT_SVC_EN   = 0;
  localparam int BIT_END_LO   = 1;
  localparam int BIT_END_HI   = 2;
  localparam int BIT_BUSY     = 3;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_STOP = 1;
  // End codes
  localparam logic [1:0] END_NONE  = 2'b00;
  localparam logic [1:0] END_COUNT = 2'b01;
  localparam logic [1:0] END_STOP  = 2'b11;
  // Reset values
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [23:0] PTR_RST   = 24'h00_0000;
  // Service times in machine cycles
  localparam logic [7:0] T_BASE      = 8'h20;
  localparam logic [7:0] T_PTR_UPD   = 8'h02;
  localparam logic [7:0] T_STOP_EN   = 8'h01;
  localparam logic [7:0] T_STOP_BASE = 8'h24;
  localparam logic [7:0] T_END_EXTRA = 8'h15;
  localparam logic [7:0] T_IRQ_MULT  = 8'h06;
  // Service states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD   = 3'b001,
    ST_WR   = 3'b010,
    ST_WAIT = 3'b011,
    ST_END  = 3'b100
  } svc_state_type;
endpackage

// >>> design/xfer_cost.sv
`timescale 1ns/10ps
// Service time of one request in machine cycles
module xfer_cost
  import xfer_svc_pkg::*;
(
  input  wire logic       io_upd,    // Peripheral pointer advances
  input  wire logic       buf_upd,   // Buffer pointer advances
  input  wire logic       stop_en,   // Stop on request enabled
  input  wire logic [3:0] comp,      // Access compensation 0..8
  input  wire logic [3:0] irq_comp,  // Interrupt compensation
  input  wire logic       by_stop,   // Ended by stop request
  input  wire logic       by_count,  // Ended by count
  output logic      [7:0] cycles     // Total service cycles
);
  logic [7:0] cont;
  logic [7:0] irq6;
  // Continuing cost plus access compensation
  assign cont = T_BASE + (io_upd ? T_PTR_UPD : 8'h00)
              + (buf_upd ? T_PTR_UPD : 8'h00)
              + (stop_en ? T_STOP_EN : 8'h00)
              + {4'h0, comp};
  assign irq6 = 8'(T_IRQ_MULT * {4'h0, irq_comp});
  // Termination variants
  always_comb begin
    if (by_stop) begin
      cycles = T_STOP_BASE + irq6;
    end else if (by_count) begin
      cycles = cont + T_END_EXTRA + irq6;
    end else begin
      cycles = cont;
    end
  end
endmodule

// >>> design/xfer_service.sv
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// How it works
// - Width bit picks byte or word
// - Buffer hold bit freezes buffer pointer
// - Buffer advance touches low sixteen bits only
// - Direction bit picks peripheral-to-buffer or reverse
// - Stop bit lets peripheral stop end service
// - Twenty-four bit buffer pointer per channel
// - Base 32 cycles plus update extras
// - Access compensation zero to eight added
// - Stop ending costs 36 plus six compensations
// - Count ending adds 21 plus six compensations
// - Peripheral hold bit freezes peripheral pointer
// - Counter decrements before move, ends at zero
// - End code recorded, service enable cleared
module xfer_service
  import xfer_svc_pkg::*;
(
  input  wire logic        sys_clk,     // 100 MHz clock
  input  wire logic        rst,         // Synchronous reset
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB enable
  input  wire logic        pwrite,      // APB write
  input  wire logic [7:0]  paddr,       // APB address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic      [31:0] prdata,      // APB read data
  output logic             pready,      // APB ready
  output logic             pslverr,     // APB error
  input  wire logic        periph_req,  // Peripheral service request
  input  wire logic        periph_stop, // Peripheral stop request
  input  wire logic [3:0]  access_comp, // Access compensation
  input  wire logic [3:0]  irq_comp,    // Interrupt compensation
  output logic      [23:0] mem_addr,    // Memory address
  output logic             mem_rd,      // Memory read strobe
  output logic             mem_wr,      // Memory write strobe
  output logic             mem_word,    // Word access
  output logic      [15:0] mem_wdata,   // Memory write data
  input  wire logic [15:0] mem_rdata,   // Memory read data
  output logic             end_irq,     // Peripheral routine request
  output logic             irq          // Interrupt output
);
  logic [7:0]    ctrl_r;
  logic [15:0]   count_r;
  logic [15:0]   ioptr_r;
  logic [23:0]   bufptr_r;
  logic          svc_en_r;
  logic [1:0]    end_r;
  logic [1:0]    ist_r;
  logic [1:0]    imask_r;
  logic [7:0]    busy_cyc_r;
  logic [7:0]    wait_r;
  logic          stop_hit_r;
  svc_state_type st_r;
  logic [1:0]    req_sync_r;
  logic [1:0]    stop_sync_r;
  logic          req_d_r;
  logic [23:0]   mem_addr_r;
  logic          mem_rd_r;
  logic          mem_wr_r;
  logic [15:0]   mem_wdata_r;
  logic          end_irq_r;
  logic          irq_r;
  logic [31:0]   prdata_r;
  logic          pready_r;
  logic          pslverr_r;

  // Decoded controls
  wire acc      = psel & penable & ~pready_r;
  wire wr_acc   = acc & pwrite;
  wire rd_acc   = acc & ~pwrite;
  wire word     = ctrl_r[BIT_WIDTH];
  wire dir_out  = ctrl_r[BIT_DIR];
  wire buf_upd  = ~ctrl_r[BIT_BUF_HOLD];
  wire io_upd   = ~ctrl_r[BIT_IO_HOLD];
  wire stop_en  = ctrl_r[BIT_STOP_EN];
  wire req      = req_sync_r[1];
  wire stop     = stop_sync_r[1];
  wire req_rise = req & ~req_d_r;
  wire [15:0] step = word ? 16'h0002 : 16'h0001;
  wire [15:0] cnt_dec = count_r - 16'h0001;
  wire stop_now = stop_en & stop;
  wire mapped = (paddr[7:5] == 3'b000) & (paddr[1:0] == 2'b00);
  wire [7:0] cost;
  wire busy = (st_r != ST_IDLE);
  wire ending = stop_hit_r | (count_r == 16'h0000);
  // Terminating services spend one more cycle in the end state
  wire [7:0] wait_last = ending ? cost - 8'h02 : cost - 8'h01;
  wire [31:0] rd_mux =
      (paddr == OFS_CTRL)     ? {24'h0000_00, ctrl_r} :
      (paddr == OFS_COUNT)    ? {16'h0000, count_r} :
      (paddr == OFS_IOPTR)    ? {16'h0000, ioptr_r} :
      (paddr == OFS_BUFPTR)   ? {8'h00, bufptr_r} :
      (paddr == OFS_STATUS)   ? {28'h000_0000,
                                 (st_r != ST_IDLE), end_r, svc_en_r} :
      (paddr == OFS_IRQ_STAT) ? {30'h0000_0000, ist_r} :
      (paddr == OFS_IRQ_MASK) ? {30'h0000_0000, imask_r} :
      32'h0000_0000;
  wire set_done = (st_r == ST_END) & (end_r == END_COUNT);
  wire set_stop = (st_r == ST_END) & (end_r == END_STOP);
  wire [1:0] ist_set = {set_stop, set_done};
  wire [1:0] ist_clr = (wr_acc & (paddr == OFS_IRQ_STAT)) ?
                       pwdata[1:0] : 2'b00;

  // Service time for the current request
  xfer_cost xfer_cost_i (
    .io_upd   (io_upd),
    .buf_upd  (buf_upd),
    .stop_en  (stop_en),
    .comp     (access_comp),
    .irq_comp (irq_comp),
    .by_stop  (stop_hit_r),
    .by_count (count_r == 16'h0000),
    .cycles   (cost)
  );

  // Pin synchronisers; first stage read only by second
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_sync_r  <= 2'b00;
      stop_sync_r <= 2'b00;
      req_d_r     <= 1'b0;
    end else begin
      req_sync_r  <= {req_sync_r[0], periph_req};
      stop_sync_r <= {stop_sync_r[0], periph_stop};
      req_d_r     <= req;
    end
  end

  // Busy-cycle count, read only by the service-time check
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_cyc_r <= 8'h00;
    end else if (busy) begin
      busy_cyc_r <= busy_cyc_r + 8'h01;
    end else begin
      busy_cyc_r <= 8'h00;
    end
  end

  // APB slave: one wait state, unmapped reads zero with error
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= acc;
      pslverr_r <= acc & ~mapped;
      prdata_r  <= rd_acc ? rd_mux : 32'h0000_0000;
    end
  end

  // Sticky interrupt status, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ist_r   <= 2'b00;
      imask_r <= 2'b00;
      irq_r   <= 1'b0;
    end else begin
      ist_r <= (ist_r & ~ist_clr) | ist_set;
      if (wr_acc & (paddr == OFS_IRQ_MASK)) begin
        imask_r <= pwdata[1:0];
      end
      irq_r <= |(ist_r & imask_r);
    end
  end

  // Transfer engine; software writes are ignored while busy
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r      <= CTRL_RST;
      count_r     <= COUNT_RST;
      ioptr_r     <= COUNT_RST;
      bufptr_r    <= PTR_RST;
      svc_en_r    <= 1'b0;
      end_r       <= END_NONE;
      wait_r      <= 8'h00;
      stop_hit_r  <= 1'b0;
      st_r        <= ST_IDLE;
      mem_addr_r  <= PTR_RST;
      mem_rd_r    <= 1'b0;
      mem_wr_r    <= 1'b0;
      mem_wdata_r <= 16'h0000;
      end_irq_r   <= 1'b0;
    end else begin
      mem_rd_r  <= 1'b0;
      mem_wr_r  <= 1'b0;
      end_irq_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (wr_acc) begin
            if (paddr == OFS_CTRL) ctrl_r <= {3'b000, pwdata[4:0]};
            if (paddr == OFS_COUNT) count_r <= pwdata[15:0];
            if (paddr == OFS_IOPTR) ioptr_r <= pwdata[15:0];
            if (paddr == OFS_BUFPTR) bufptr_r <= pwdata[23:0];
            if (paddr == OFS_STATUS) begin
              svc_en_r <= pwdata[BIT_SVC_EN];
              if (pwdata[BIT_SVC_EN]) end_r <= END_NONE;
            end
          end
          if (svc_en_r & stop_now & req_rise) begin
            stop_hit_r <= 1'b1;
            st_r       <= ST_WAIT;
            wait_r     <= 8'h01;
          end else if (svc_en_r & req_rise) begin
            count_r    <= cnt_dec;
            stop_hit_r <= 1'b0;
            st_r       <= ST_RD;
            mem_rd_r   <= 1'b1;
            mem_addr_r <= dir_out ? bufptr_r : {8'h00, ioptr_r};
          end
        end
        ST_RD: begin
          mem_wr_r    <= 1'b1;
          mem_wdata_r <= word ? mem_rdata : {8'h00, mem_rdata[7:0]};
          mem_addr_r  <= dir_out ? {8'h00, ioptr_r} : bufptr_r;
          st_r        <= ST_WR;
        end
        ST_WR: begin
          if (io_upd) ioptr_r <= ioptr_r + step;
          if (buf_upd) begin
            bufptr_r[15:0] <= bufptr_r[15:0] + step;
          end
          wait_r <= 8'h03;
          st_r   <= ST_WAIT;
        end
        ST_WAIT: begin
          // Pad until the service time has elapsed, so every kind of
          // service stays busy for the cost less one cycle
          if (wait_r >= wait_last) begin
            if (ending) begin
              st_r <= ST_END;
              end_r <= stop_hit_r ? END_STOP : END_COUNT;
            end else begin
              st_r <= ST_IDLE;
            end
          end else begin
            wait_r <= wait_r + 8'h01;
          end
        end
        ST_END: begin
          svc_en_r  <= 1'b0;
          end_irq_r <= 1'b1;
          st_r      <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign mem_addr  = mem_addr_r;
  assign mem_rd    = mem_rd_r;
  assign mem_wr    = mem_wr_r;
  assign mem_word  = word;
  assign mem_wdata = mem_wdata_r;
  assign end_irq   = end_irq_r;
  assign irq       = irq_r;
  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;

  // Checks
  property p_buf_high;
    @(posedge sys_clk) disable iff (rst)
      (st_r == ST_WR) |=> bufptr_r[23:16] == $past(bufptr_r[23:16]);
  endproperty
  a_buf_high: assert property (p_buf_high) else $error("upper moved");
  property p_buf_step;
    @(posedge sys_clk) disable iff (rst)
      (st_r == ST_WR && buf_upd) |=>
      bufptr_r[15:0] == 16'($past(bufptr_r[15:0]) + (word ? 2 : 1));
  endproperty
  a_buf_step: assert property (p_buf_step) else $error("bad buf step");
  property p_buf_hold;
    @(posedge sys_clk) disable iff (rst)
      (st_r == ST_WR && !buf_upd) |=> $stable(bufptr_r);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("buf ptr moved");
  property p_io_hold;
    @(posedge sys_clk) disable iff (rst)
      (st_r == ST_WR && !io_upd) |=> $stable(ioptr_r);
  endproperty
  a_io_hold: assert property (p_io_hold) else $error("io ptr moved");
  property p_dec;
    @(posedge sys_clk) disable iff (rst)
      (st_r == ST_IDLE && svc_en_r && req_rise && !stop_now) |=>
      count_r == 16'($past(count_r) - 1) ##1 mem_wr;
  endproperty
  a_dec: assert property (p_dec) else $error("no decrement");
  property p_dir;
    @(posedge sys_clk) disable iff (rst)
      mem_wr && dir_out |-> mem_addr[23:16] == 8'h00;
  endproperty
  a_dir: assert property (p_dir) else $error("bad out address");
  property p_end;
    @(posedge sys_clk) disable iff (rst)
      (st_r == ST_END) |=> !svc_en_r && end_irq && end_r != END_NONE;
  endproperty
  a_end: assert property (p_end) else $error("bad termination");
  property p_stop;
    @(posedge sys_clk) disable iff (rst)
      (st_r == ST_IDLE && svc_en_r && req_rise && stop_now) |=>
      !mem_rd ##[1:200] (end_r == END_STOP);
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  c_word: cover property (@(posedge sys_clk) mem_wr && word);
  c_count_end: cover property (@(posedge sys_clk) set_done);
  c_stop_end: cover property (@(posedge sys_clk) set_stop);
  c_buf_held: cover property (@(posedge sys_clk) mem_wr && !buf_upd);
  // The request cycle counts as the first one, so busy lasts cost less one
  property p_svc_time;
    @(posedge sys_clk) disable iff (rst)
      $fell(busy) |-> busy_cyc_r == cost - 8'h01;
  endproperty
  a_svc_time: assert property (p_svc_time) else $error("bad svc time");
  property p_cost_cont;
    @(posedge sys_clk) disable iff (rst)
      busy && !ending |->
        cost >= T_BASE + {4'h0, access_comp} &&
        cost <= T_BASE + T_PTR_UPD + T_PTR_UPD + T_STOP_EN
                + {4'h0, access_comp};
  endproperty
  a_cost_cont: assert property (p_cost_cont) else $error("bad cost");
  property p_cost_stop;
    @(posedge sys_clk) disable iff (rst)
      busy && stop_hit_r |->
        cost == T_STOP_BASE + 8'(T_IRQ_MULT * {4'h0, irq_comp});
  endproperty
  a_cost_stop: assert property (p_cost_stop) else $error("bad stop cost");
  property p_cost_end;
    @(posedge sys_clk) disable iff (rst)
      busy && !stop_hit_r && ending |->
        cost >= T_BASE + T_END_EXTRA + 8'(T_IRQ_MULT * {4'h0, irq_comp});
  endproperty
  a_cost_end: assert property (p_cost_end) else $error("bad end cost");
  // Software load of the pointer lands only while idle
  property p_buf_load;
    @(posedge sys_clk) disable iff (rst)
      wr_acc && !busy && paddr == OFS_BUFPTR |=>
        bufptr_r == $past(pwdata[23:0]);
  endproperty
  a_buf_load: assert property (p_buf_load) else $error("bad ptr load");
  // End events stick even when a clear arrives in the same cycle
  property p_ist_set;
    @(posedge sys_clk) disable iff (rst)
      ist_set != 2'b00 |=> (ist_r & $past(ist_set)) == $past(ist_set);
  endproperty
  a_ist_set: assert property (p_ist_set) else $error("end event lost");
endmodule

// >>> verification/descriptor_transfer_service_bench.sv
`timescale 1ns/10ps
module descriptor_transfer_service_bench;
  import xfer_svc_pkg::*;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, err_seen, mem_rd, mem_wr, mem_word;
  logic periph_req = 0, periph_stop = 0, end_irq, irq;
  logic [3:0] access_comp = 4'h3, irq_comp = 4'h2;
  logic [23:0] mem_addr, wr_addr;
  logic [15:0] mem_wdata, mem_rdata, wr_data;
  logic wr_word;
  int wr_cnt, bad_count = 0, checked = 0, ends = 0, w0;

  xfer_service xfer_service_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_req(periph_req), .periph_stop(periph_stop),
    .access_comp(access_comp), .irq_comp(irq_comp), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_word(mem_word),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .end_irq(end_irq),
    .irq(irq));
  mem_side_model mem_side_model_i (.sys_clk(sys_clk), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_word(mem_word),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_word(wr_word), .wr_cnt(wr_cnt));

  // Clock and end-of-service pulse counter
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (end_irq === 1'b1) ends++;

  task final_report();
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; an idle edge first keeps psel from being driven
  // twice in one time step on back-to-back calls
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin bad_count++; final_report(); end
    q = prdata;
    err_seen = pslverr;
    psel <= 0; penable <= 0;
  endtask

  // One peripheral request, waited out through the busy flag
  task service(input logic stop);
    int n;
    periph_stop <= stop;
    periph_req <= 1;
    n = 0;
    do begin apb(0, OFS_STATUS, 0); n++; end
      while (q[BIT_BUSY] !== 1'b1 && n < 10);
    if (q[BIT_BUSY] !== 1'b1) begin bad_count++; final_report(); end
    do begin apb(0, OFS_STATUS, 0); n++; end
      while (q[BIT_BUSY] !== 1'b0 && n < 60);
    if (q[BIT_BUSY] !== 1'b0) begin bad_count++; final_report(); end
    periph_req <= 0;
    repeat (4) @(posedge sys_clk);
  endtask

  task setup(input logic [7:0] c, input logic [15:0] n, input logic [15:0] io,
             input logic [23:0] b);
    apb(1, OFS_CTRL, {24'h00_0000, c});
    apb(1, OFS_COUNT, {16'h0000, n});
    apb(1, OFS_IOPTR, {16'h0000, io});
    apb(1, OFS_BUFPTR, {8'h00, b});
    apb(1, OFS_STATUS, 32'h0000_0001);
  endtask

  task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk(name, q, exp);
  endtask

  // Reset values, reserved and unmapped places
  task t_reset();
    rd("ctrl", OFS_CTRL, 32'h0000_0000);
    rd("count", OFS_COUNT, 32'h0000_0000);
    rd("status", OFS_STATUS, 32'h0000_0000);
    rd("reserved", OFS_TRIG, 32'h0000_0000);
    chk("slverr0", {31'h0, err_seen}, 32'h0000_0000);
    rd("unmapped", 8'h40, 32'h0000_0000);
    chk("slverr", {31'h0, err_seen}, 32'h0000_0001);
  endtask

  // Byte moves peripheral to buffer, both pointers advance, count ends
  task t_byte_in();
    setup(8'h00, 16'h0002, 16'h0040, 24'h34_00F0);
    apb(1, OFS_IRQ_MASK, 32'h0000_0003);
    service(0);
    chk("waddr", {8'h00, wr_addr}, 32'h0034_00F0);
    chk("wdata", {16'h0, wr_data}, 32'h0000_0040);
    rd("buf", OFS_BUFPTR, 32'h0034_00F1);
    rd("io", OFS_IOPTR, 32'h0000_0041);
    rd("cnt", OFS_COUNT, 32'h0000_0001);
    rd("stat", OFS_STATUS, 32'h0000_0001);
    service(0);
    chk("waddr2", {8'h00, wr_addr}, 32'h0034_00F1);
    rd("end", OFS_STATUS, 32'h0000_0002);
    rd("istat", OFS_IRQ_STAT, 32'h0000_0001);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    chk("ends", ends, 1);
    apb(1, OFS_IRQ_STAT, 32'h0000_0001);
    @(posedge sys_clk);
    chk("irq_clr", {31'h0, irq}, 32'h0000_0000);
  endtask

  // Word moves buffer to peripheral, low half wraps, stop ignored
  task t_word_out();
    setup(8'h1A, 16'h0001, 16'h0123, 24'h12_FFFE);
    w0 = wr_cnt;
    service(1);
    chk("wcnt", wr_cnt, w0 + 1);
    chk("waddr", {8'h00, wr_addr}, 32'h0000_0123);
    chk("wdata", {16'h0, wr_data}, 32'h0000_A4FE);
    chk("wword", {31'h0, wr_word}, 32'h0000_0001);
    rd("buf", OFS_BUFPTR, 32'h0012_0000);
    rd("io", OFS_IOPTR, 32'h0000_0123);
    rd("end", OFS_STATUS, 32'h0000_0002);
  endtask

  // Stop bit set: a plain request moves with the buffer pointer held;
  // a stop request then ends service without a move; mask holds irq low
  task t_stop();
    access_comp <= 4'h8;
    apb(1, OFS_IRQ_STAT, 32'h0000_0003);
    apb(1, OFS_IRQ_MASK, 32'h0000_0001);
    setup(8'h05, 16'h0005, 16'h0010, 24'h00_1000);
    service(0);
    chk("waddr3", {8'h00, wr_addr}, 32'h0000_1000);
    chk("wdata3", {16'h0, wr_data}, 32'h0000_0010);
    rd("buf3", OFS_BUFPTR, 32'h0000_1000);
    rd("io3", OFS_IOPTR, 32'h0000_0011);
    w0 = wr_cnt;
    service(1);
    chk("nomove", wr_cnt, w0);
    rd("cnt", OFS_COUNT, 32'h0000_0004);
    rd("end", OFS_STATUS, 32'h0000_0006);
    rd("istat", OFS_IRQ_STAT, 32'h0000_0002);
    chk("masked", {31'h0, irq}, 32'h0000_0000);
    apb(1, OFS_IRQ_MASK, 32'h0000_0003);
    @(posedge sys_clk);
    chk("unmask", {31'h0, irq}, 32'h0000_0001);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    t_reset();
    t_byte_in();
    t_word_out();
    t_stop();
    final_report();
  end
endmodule

// >>> verification/mem_side_model.sv
`timescale 1ns/10ps
// Memory and peripheral register space seen by the transfer service
module mem_side_model (
  input  wire logic        sys_clk,   // Machine clock
  input  wire logic [23:0] mem_addr,  // Access address
  input  wire logic        mem_rd,    // Read strobe
  input  wire logic        mem_wr,    // Write strobe
  input  wire logic        mem_word,  // Word access
  input  wire logic [15:0] mem_wdata, // Write data
  output logic      [15:0] mem_rdata, // Read data
  output logic      [23:0] wr_addr,   // Last write address
  output logic      [15:0] wr_data,   // Last write data
  output logic             wr_word,   // Last write width
  output int               wr_cnt     // Writes seen
);
  logic [15:0] idle_r = 16'h0000;
  int          cnt_r = 0;
  // Data is a pattern of the address while the read strobe stands, so
  // the engine finds it at the edge that ends the strobe; otherwise the
  // bus toggles every cycle so a late sample never sees a stale match
  assign mem_rdata = (mem_rd === 1'b1) ?
                     {mem_addr[7:0] ^ 8'h5A, mem_addr[7:0]} : idle_r;
  assign wr_cnt = cnt_r;
  always @(posedge sys_clk) begin
    idle_r <= ~idle_r;
    if (mem_wr === 1'b1) begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
      wr_word <= mem_word;
      cnt_r <= cnt_r + 1;
    end
  end
endmodule
